/* File: core/transition_data_codec_port.sv */
/*
 * serial backplane port and terminal data front end of a transition
 * encoded data codec: control byte and data word shift in, encoded word
 * shifts out, terminal line decoding, activity and scan point flags.
 * assumes all port and terminal pins are asynchronous to clk_sys and that
 * port_clk runs well below a quarter of the clk_sys rate.
 */
// Local design decisions: the placing of the registers and the address-and-strobe port.
// Function
// R01 - carry terminal data up to 19.2 kbps
// R02 - control register loads from serial control input
// R03 - control register steers mode and flag clears
// R04 - control register refreshed once per enabled frame
// R05 - accept 8-bit data word while enabled
// R06 - controller supplies the 2.048 MHz port clock
// R07 - serial output driven only in enabled window
// R08 - frame pulse sampled on every port clock rise
// R09 - port active only while strobe and frame low
// R10 - format pin selects RZ or NRZ data
// R11 - energy assertion latches the last pulsed line
// R12 - activity and scan flags work only with energy
// R13 - loopback modes force received energy active
// R14 - terminal keeps energy low during a call
// R15 - NRZ reads primary line, high is mark
// R16 - RZ takes active-low pulses, polarity from latch
// R17 - mode bits; mode 6 raises drive point
// R18 - control bit 1 clears activity flag
// R19 - control bit 0 clears scan point output
// R20 - control bits shifted, then loaded at window end
`timescale 1ns/1ns
`default_nettype none
module transition_data_codec_port #(
	parameter int unsigned SAMPLE_CYCLES = codec_port_pkg::SAMPLE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic port_clk,
	input wire logic frame_pulse_n,
	input wire logic chan_addr_n,
	input wire logic ctrl_serial_in,
	input wire logic port_data_in,
	output logic port_data_out,
	output logic port_data_oe,
	input wire logic format_sel,
	input wire logic rx_energy_n,
	input wire logic tx_line_a,
	input wire logic tx_line_b,
	input wire logic scan_point_in,
	output logic activity_flag,
	output logic scan_point_out,
	output logic drive_point_out,
	output logic [codec_port_pkg::WORD_BITS-1:0] rx_word,
	output logic rx_word_valid
);
	localparam int WB = codec_port_pkg::WORD_BITS;
	localparam int CW = codec_port_pkg::CNT_W;
	localparam int SW = codec_port_pkg::SAMPLE_CNT_W;

	generate
		if (SAMPLE_CYCLES < 3 || SAMPLE_CYCLES >= (1 << SW)) begin : g_bad
			$error("SAMPLE_CYCLES out of range");
		end
	endgenerate

	function automatic logic is_loop(input codec_port_pkg::op_mode_t m);
		is_loop = (m == codec_port_pkg::MODE_4) || (m == codec_port_pkg::MODE_5)
			|| (m == codec_port_pkg::MODE_6);
	endfunction

	// ==========================================================
	// reset release
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// pin synchronisers
	logic [codec_port_pkg::PIN_COUNT-1:0] pin_raw;
	logic [codec_port_pkg::PIN_COUNT-1:0] pin_s;
	assign pin_raw[codec_port_pkg::PIN_PCLK] = port_clk;
	assign pin_raw[codec_port_pkg::PIN_FRAME] = frame_pulse_n;
	assign pin_raw[codec_port_pkg::PIN_ADDR] = chan_addr_n;
	assign pin_raw[codec_port_pkg::PIN_CTRL] = ctrl_serial_in;
	assign pin_raw[codec_port_pkg::PIN_DATA] = port_data_in;
	assign pin_raw[codec_port_pkg::PIN_FMT] = format_sel;
	assign pin_raw[codec_port_pkg::PIN_RXE] = rx_energy_n;
	assign pin_raw[codec_port_pkg::PIN_TXA] = tx_line_a;
	assign pin_raw[codec_port_pkg::PIN_TXB] = tx_line_b;
	assign pin_raw[codec_port_pkg::PIN_SCAN] = scan_point_in;

	pin_sync #(
		.WIDTH(codec_port_pkg::PIN_COUNT),
		.RESET_VAL(codec_port_pkg::PIN_RESET)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d(pin_raw),
		.q(pin_s)
	);

	wire pclk_s = pin_s[codec_port_pkg::PIN_PCLK];
	wire frame_s = pin_s[codec_port_pkg::PIN_FRAME];
	wire addr_s = pin_s[codec_port_pkg::PIN_ADDR];
	wire ctrl_s = pin_s[codec_port_pkg::PIN_CTRL];
	wire data_s = pin_s[codec_port_pkg::PIN_DATA];
	wire fmt_s = pin_s[codec_port_pkg::PIN_FMT];
	wire rxe_s = pin_s[codec_port_pkg::PIN_RXE];
	wire txa_s = pin_s[codec_port_pkg::PIN_TXA];
	wire txb_s = pin_s[codec_port_pkg::PIN_TXB];
	wire scan_s = pin_s[codec_port_pkg::PIN_SCAN];

	// ==========================================================
	// port clock edge and window decode
	logic pclk_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pclk_q <= 1'b1;
		end else begin
			pclk_q <= pclk_s; // R06
		end
	end

	wire pclk_rise = pclk_s & ~pclk_q;
	// frame pulse and strobe both low open the port
	wire win_now = ~frame_s & ~addr_s; // R09

	// ==========================================================
	// port window state machine
	codec_port_pkg::port_state_t port_state;
	codec_port_pkg::port_state_t next_port_state;
	logic [CW-1:0] bit_cnt;
	logic [WB-1:0] ctrl_shift;
	logic [WB-1:0] data_shift;
	logic [WB-1:0] out_shift;
	logic [WB-1:0] ctrl_reg;
	logic loaded_frame;

	always_comb begin
		next_port_state = port_state;
		unique case (port_state)
			codec_port_pkg::PORT_IDLE: begin
				if (pclk_rise && win_now) begin
					next_port_state = codec_port_pkg::PORT_OPEN;
				end
			end
			codec_port_pkg::PORT_OPEN: begin
				if (pclk_rise && !win_now) begin
					next_port_state = codec_port_pkg::PORT_IDLE;
				end else if (pclk_rise && bit_cnt == codec_port_pkg::CNT_FULL - codec_port_pkg::CNT_ONE) begin
					next_port_state = codec_port_pkg::PORT_FULL;
				end
			end
			codec_port_pkg::PORT_FULL: begin
				if (pclk_rise && !win_now) begin
					next_port_state = codec_port_pkg::PORT_IDLE;
				end
			end
			default: begin
				next_port_state = codec_port_pkg::PORT_IDLE;
			end
		endcase
	end

	wire in_idle = (port_state == codec_port_pkg::PORT_IDLE);
	wire open_win = pclk_rise && in_idle && win_now;
	wire take_bit = pclk_rise && win_now && (port_state != codec_port_pkg::PORT_FULL); // R05
	wire close_win = pclk_rise && !win_now && !in_idle;
	wire frame_gap = pclk_rise && frame_s; // R08
	wire ctrl_load = close_win && !loaded_frame && (bit_cnt == codec_port_pkg::CNT_FULL); // R04
	wire next_oe = win_now && (next_port_state != codec_port_pkg::PORT_IDLE); // R07

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			port_state <= codec_port_pkg::PORT_IDLE;
			bit_cnt <= codec_port_pkg::CNT_ZERO;
		end else begin
			port_state <= next_port_state;
			if (open_win) begin
				bit_cnt <= codec_port_pkg::CNT_ONE;
			end else if (take_bit) begin
				bit_cnt <= bit_cnt + codec_port_pkg::CNT_ONE;
			end
		end
	end

	// ==========================================================
	// serial input capture, msb first
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_shift <= codec_port_pkg::CTRL_RESET;
			data_shift <= codec_port_pkg::IDLE_WORD;
		end else if (take_bit) begin
			ctrl_shift <= {ctrl_shift[WB-2:0], ctrl_s}; // R20
			data_shift <= {data_shift[WB-2:0], data_s}; // R05
		end
	end

	// control byte moves over whole, once per frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= codec_port_pkg::CTRL_RESET;
			loaded_frame <= 1'b0;
		end else begin
			if (ctrl_load) begin
				ctrl_reg <= ctrl_shift; // R02 R20
			end
			// a frame gap at the closing rise already starts the next frame
			if (frame_gap) begin
				loaded_frame <= 1'b0; // R04
			end else if (ctrl_load) begin
				loaded_frame <= 1'b1; // R04
			end
		end
	end

	// received word is handed on when the window closes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_word <= codec_port_pkg::IDLE_WORD;
			rx_word_valid <= 1'b0;
		end else begin
			rx_word_valid <= close_win && (bit_cnt == codec_port_pkg::CNT_FULL);
			if (close_win && bit_cnt == codec_port_pkg::CNT_FULL) begin
				rx_word <= data_shift; // R05
			end
		end
	end

	// ==========================================================
	// mode decode
	codec_port_pkg::op_mode_t mode;
	assign mode = codec_port_pkg::op_mode_t'(
		ctrl_reg[codec_port_pkg::MODE_HI:codec_port_pkg::MODE_LO]); // R03 R17
	wire loop_mode = is_loop(mode);
	wire clr_act = ctrl_reg[codec_port_pkg::CLR_ACT_BIT]; // R03
	wire clr_scan = ctrl_reg[codec_port_pkg::CLR_SCAN_BIT]; // R03

	// ==========================================================
	// terminal line decode
	logic txa_q;
	logic txb_q;
	logic scan_q;
	logic energy_q;
	logic last_b;
	logic mark_is_b;
	logic rz_level;

	wire rz = fmt_s; // R10
	// loopback ignores the energy pin
	wire energy_act = loop_mode | ~rxe_s; // R13
	wire energy_rise = energy_act & ~energy_q;
	wire pulse_a = ~txa_s & txa_q;
	wire pulse_b = ~txb_s & txb_q;
	wire mark_pulse = mark_is_b ? pulse_b : pulse_a; // R16
	wire space_pulse = mark_is_b ? pulse_a : pulse_b; // R16
	// the line that pulsed last is the mark line, so the level is mark on latching
	wire rz_mark = rz_level | energy_rise; // R11
	wire term_mark = rz ? rz_mark : txa_s; // R10 R15
	wire act_set = energy_act & ~term_mark; // R12
	wire scan_set = energy_act & scan_s & ~scan_q; // R12

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			txa_q <= 1'b1;
			txb_q <= 1'b1;
			scan_q <= 1'b1;
			energy_q <= 1'b0;
		end else begin
			txa_q <= txa_s;
			txb_q <= txb_s;
			scan_q <= scan_s;
			energy_q <= energy_act;
		end
	end

	// polarity: remember the line that pulsed last, latch it on energy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			last_b <= 1'b0;
			mark_is_b <= 1'b0;
		end else begin
			if (pulse_b && !pulse_a) begin
				last_b <= 1'b1;
			end else if (pulse_a && !pulse_b) begin
				last_b <= 1'b0;
			end
			if (rz && energy_rise) begin
				mark_is_b <= last_b; // R11
			end
		end
	end

	// rz pulses rebuilt into a held level, idle is mark
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rz_level <= 1'b1;
		end else if (rz && energy_rise) begin
			rz_level <= 1'b1; // R11
		end else if (mark_pulse) begin
			rz_level <= 1'b1; // R16
		end else if (space_pulse) begin
			rz_level <= 1'b0; // R16
		end
	end

	// ==========================================================
	// status outputs; a set in the same cycle beats the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			activity_flag <= 1'b0;
			scan_point_out <= 1'b1;
			drive_point_out <= 1'b0;
		end else begin
			if (act_set) begin
				activity_flag <= 1'b1; // R12
			end else if (clr_act) begin
				activity_flag <= 1'b0; // R18
			end
			if (scan_set) begin
				scan_point_out <= 1'b0; // R12
			end else if (clr_scan) begin
				scan_point_out <= 1'b1; // R19
			end
			drive_point_out <= (mode == codec_port_pkg::MODE_6); // R17
		end
	end

	// ==========================================================
	// terminal sampler, 64 kHz enable from a divider
	logic [SW-1:0] samp_cnt;
	logic [WB-1:0] sample_word;
	wire samp_en = (samp_cnt == SW'(SAMPLE_CYCLES - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			samp_cnt <= '0;
			sample_word <= codec_port_pkg::IDLE_WORD;
		end else begin
			samp_cnt <= samp_en ? '0 : samp_cnt + SW'(1);
			if (samp_en) begin
				sample_word <= {sample_word[WB-2:0], term_mark}; // R01
			end
		end
	end

	// loopback returns the last received word
	wire [WB-1:0] enc_word = loop_mode ? rx_word : sample_word;

	// ==========================================================
	// serial output, msb first, next bit on each port clock rise
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_shift <= codec_port_pkg::IDLE_WORD;
			port_data_out <= 1'b1;
			port_data_oe <= 1'b0;
		end else begin
			port_data_oe <= next_oe; // R07 R09
			if (open_win) begin
				out_shift <= {enc_word[WB-2:0], 1'b1};
				port_data_out <= enc_word[WB-1]; // R07
			end else if (take_bit) begin
				out_shift <= {out_shift[WB-2:0], 1'b1};
				port_data_out <= out_shift[WB-1]; // R07
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_window_close;
		!in_idle ##0 pclk_rise ##0 !win_now;
	endsequence

	sequence s_rz_energy;
		rz ##0 energy_rise;
	endsequence

	AST_OE_OFF_WINDOW: assert property (!win_now |=> !port_data_oe) // R09
		else $error("output enabled outside port window");
	AST_OE_IN_WINDOW: assert property (open_win |=> port_data_oe) // R07
		else $error("output not enabled after window opened");
	AST_CTRL_VALUE: assert property (ctrl_load |=> ctrl_reg == $past(ctrl_shift)) // R20
		else $error("control register not loaded from shift");
	AST_CTRL_ONCE: assert property (ctrl_load |=> !ctrl_load[*2]) // R04
		else $error("control register loaded twice");
	AST_CTRL_HOLD: assert property (!ctrl_load |=> $stable(ctrl_reg)) // R02
		else $error("control register changed without load");
	AST_CLOSE_IDLE: assert property (s_window_close |=> in_idle) // R09
		else $error("window did not close");
	AST_DRIVE_POINT: assert property (##1 drive_point_out ==
		($past(ctrl_reg[codec_port_pkg::MODE_HI:codec_port_pkg::MODE_LO]) ==
		codec_port_pkg::MODE_6)) // R17
		else $error("drive point wrong for mode");
	AST_FRAME_GAP: assert property (frame_gap |=> !loaded_frame) // R04
		else $error("frame gap did not rearm control load");
	AST_LOOP_ENERGY: assert property (loop_mode |-> energy_act) // R13
		else $error("energy not forced in loopback");
	AST_ACT_GATE: assert property ((!energy_act && !activity_flag) |=> !activity_flag) // R12
		else $error("activity set without energy");
	AST_ACT_CLEAR: assert property ((clr_act && !act_set) |=> !activity_flag) // R18
		else $error("activity flag not cleared");
	AST_SCAN_SET: assert property (scan_set |=> !scan_point_out) // R12
		else $error("scan point not set low");
	AST_NRZ_LEVEL: assert property (!rz |-> term_mark == txa_s) // R15
		else $error("nrz level not from primary line");
	AST_POL_LATCH: assert property (s_rz_energy |=> mark_is_b == $past(last_b)) // R11
		else $error("polarity not latched");
	AST_SAMPLE_RATE: assert property (samp_en |=> !samp_en[*2]) // R01
		else $error("sample enable too frequent");
endmodule
`default_nettype wire

/* File: core/codec_port_pkg.sv */
/*
 * constants, field positions and types shared by the codec port design.
 * assumes a 25 MHz system clock and a controller that drives the port pins.
 */
`default_nettype none
package codec_port_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	// terminal sampling period: one sample per bit of a 64 kbps channel
	localparam int SAMPLE_PERIOD_NS = 15625;
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_CNT_W = 16;
	// ==========================================================
	// words and control fields
	localparam int WORD_BITS = 8;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 5;
	localparam int CLR_ACT_BIT = 1;
	localparam int CLR_SCAN_BIT = 0;
	localparam logic [WORD_BITS-1:0] CTRL_RESET = 8'h00;
	localparam logic [WORD_BITS-1:0] IDLE_WORD = 8'hFF;
	// ==========================================================
	// synchronised pin positions
	localparam int PIN_PCLK = 0;
	localparam int PIN_FRAME = 1;
	localparam int PIN_ADDR = 2;
	localparam int PIN_CTRL = 3;
	localparam int PIN_DATA = 4;
	localparam int PIN_FMT = 5;
	localparam int PIN_RXE = 6;
	localparam int PIN_TXA = 7;
	localparam int PIN_TXB = 8;
	localparam int PIN_SCAN = 9;
	localparam int PIN_COUNT = 10;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 10'h3FF;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		MODE_0 = 3'b000, MODE_1 = 3'b001, MODE_2 = 3'b010, MODE_3 = 3'b011,
		MODE_4 = 3'b100, MODE_5 = 3'b101, MODE_6 = 3'b110, MODE_7 = 3'b111
	} op_mode_t;
	typedef enum logic [1:0] {
		PORT_IDLE = 2'b00,
		PORT_OPEN = 2'b01,
		PORT_FULL = 2'b10
	} port_state_t;
endpackage
`default_nettype wire

/* File: core/pin_sync.sv */
/*
 * two-stage synchroniser bank for asynchronous input pins.
 * assumes an active-low reset, released in step with clk_sys, from the top module.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// ==========================================================
	// one pair of flip-flops per pin
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					meta <= RESET_VAL[i];
					q[i] <= RESET_VAL[i];
				end else begin
					meta <= d[i];
					q[i] <= meta;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: testbench/backplane_model.sv */
/*
 * backplane controller model: port clock, frame and address strobes,
 * serial control and data bits, capture of the encoded output word.
 * assumes clk_sys from the bench; the port clock moves only in windows.
 */
`timescale 1ns/1ns
`default_nettype none
module backplane_model (
	input wire logic clk_sys,
	output logic port_clk,
	output logic frame_pulse_n,
	output logic chan_addr_n,
	output logic ctrl_serial_in,
	output logic port_data_in,
	input wire logic port_data_out,
	input wire logic port_data_oe
);
	// half period in clk_sys cycles, slowed to suit the synchroniser
	localparam int HALF = 8;
	logic [7:0] out_word;
	logic oe_seen;
	logic bit_seen;
	logic oe_bit;
	initial begin
		port_clk = 1'b0;
		frame_pulse_n = 1'b1;
		chan_addr_n = 1'b1;
		ctrl_serial_in = 1'b0;
		port_data_in = 1'b1;
	end
	// ==========================================================
	// one port clock period, output sampled once it has settled
	task automatic rise();
		repeat (HALF) @(posedge clk_sys);
		port_clk <= 1'b1;
		repeat (6) @(posedge clk_sys);
		bit_seen = port_data_out;
		oe_bit = port_data_oe;
		repeat (HALF - 6) @(posedge clk_sys);
		port_clk <= 1'b0;
	endtask
	// ==========================================================
	// one enabled window, msb first, closed by a rise with the address strobe high
	task automatic window(input logic [7:0] ctrl, input logic [7:0] data,
		input int nbits, input logic new_frame);
		int i;
		frame_pulse_n <= 1'b0;
		chan_addr_n <= 1'b0;
		oe_seen = 1'b1;
		for (i = 0; i < nbits; i++) begin
			ctrl_serial_in <= ctrl[7-i];
			port_data_in <= data[7-i];
			rise();
			out_word[7-i] = bit_seen;
			oe_seen = oe_seen & oe_bit;
		end
		// released lines show no stale value
		ctrl_serial_in <= ~ctrl_serial_in;
		port_data_in <= ~port_data_in;
		chan_addr_n <= 1'b1;
		// frame pulse high at the closing rise starts the next frame
		frame_pulse_n <= new_frame;
		rise();
	endtask
endmodule
`default_nettype wire

/* File: testbench/transition_data_codec_port_tb.sv */
/*
 * self-checking bench for the codec port: control loads, loopback word,
 * window rules, activity flag in NRZ and RZ formats, scan flag in NRZ.
 * assumes backplane_model drives the port pins.
 */
`timescale 1ns/1ns
`default_nettype none
module transition_data_codec_port_tb;
	logic clk_sys;
	logic arst_n;
	logic port_clk;
	logic frame_pulse_n;
	logic chan_addr_n;
	logic ctrl_serial_in;
	logic port_data_in;
	logic port_data_out;
	logic port_data_oe;
	logic format_sel;
	logic rx_energy_n;
	logic tx_line_a;
	logic tx_line_b;
	logic scan_point_in;
	logic activity_flag;
	logic scan_point_out;
	logic drive_point_out;
	logic [codec_port_pkg::WORD_BITS-1:0] rx_word;
	logic rx_word_valid;
	logic [7:0] valid_count;
	int num_errors;
	int tests_run;

	transition_data_codec_port #(.SAMPLE_CYCLES(8)) i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .port_clk(port_clk),
		.frame_pulse_n(frame_pulse_n), .chan_addr_n(chan_addr_n),
		.ctrl_serial_in(ctrl_serial_in), .port_data_in(port_data_in),
		.port_data_out(port_data_out), .port_data_oe(port_data_oe),
		.format_sel(format_sel), .rx_energy_n(rx_energy_n), .tx_line_a(tx_line_a),
		.tx_line_b(tx_line_b), .scan_point_in(scan_point_in),
		.activity_flag(activity_flag), .scan_point_out(scan_point_out),
		.drive_point_out(drive_point_out), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid)
	);
	backplane_model i_bp (
		.clk_sys(clk_sys), .port_clk(port_clk), .frame_pulse_n(frame_pulse_n),
		.chan_addr_n(chan_addr_n), .ctrl_serial_in(ctrl_serial_in),
		.port_data_in(port_data_in), .port_data_out(port_data_out),
		.port_data_oe(port_data_oe)
	);

	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (rx_word_valid === 1'b1) begin
			valid_count <= valid_count + 8'h01;
		end
	end
	// ==========================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		cyc(20000);
		num_errors++;
		end_of_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		format_sel = 1'b0;
		rx_energy_n = 1'b1;
		tx_line_a = 1'b1;
		tx_line_b = 1'b1;
		scan_point_in = 1'b0;
		valid_count = 8'h00;
		num_errors = 0;
		tests_run = 0;
		cyc(10);
		arst_n <= 1'b1;
		cyc(6);
		check(port_data_oe, 8'h00);
		check(drive_point_out, 8'h00);
		check(activity_flag, 8'h00);
		check(scan_point_out, 8'h01);
		check(rx_word, 8'hFF);
		i_bp.window(8'hC0, 8'hA5, 8, 1'b1);
		check(i_bp.oe_seen, 8'h01);
		check(i_bp.oe_bit, 8'h00);
		check(drive_point_out, 8'h01);
		check(rx_word, 8'hA5);
		check(valid_count, 8'h01);
		i_bp.window(8'hC0, 8'h3C, 8, 1'b0);
		check(i_bp.out_word, 8'hA5);
		check(rx_word, 8'h3C);
		i_bp.window(8'h00, 8'h5A, 8, 1'b1);
		check(drive_point_out, 8'h01);
		check(i_bp.out_word, 8'h3C);
		i_bp.window(8'h00, 8'h66, 8, 1'b1);
		check(drive_point_out, 8'h00);
		i_bp.window(8'hC0, 8'h11, 5, 1'b1);
		check(drive_point_out, 8'h00);
		check(rx_word, 8'h66);
		check(valid_count, 8'h04);
		// NRZ activity, first without energy
		tx_line_a <= 1'b0;
		cyc(10);
		check(activity_flag, 8'h00);
		rx_energy_n <= 1'b0;
		cyc(6);
		check(activity_flag, 8'h01);
		tx_line_a <= 1'b1;
		i_bp.window(8'h02, 8'h00, 8, 1'b1);
		check(activity_flag, 8'h00);
		check(i_bp.out_word, 8'hF9);
		scan_point_in <= 1'b1;
		cyc(6);
		check(scan_point_out, 8'h00);
		i_bp.window(8'h01, 8'h00, 8, 1'b1);
		check(scan_point_out, 8'h01);
		scan_point_in <= 1'b0;
		// loopback mode forces energy
		rx_energy_n <= 1'b1;
		i_bp.window(8'h80, 8'h00, 8, 1'b1);
		tx_line_a <= 1'b0;
		cyc(6);
		check(activity_flag, 8'h01);
		tx_line_a <= 1'b1;
		i_bp.window(8'h02, 8'h00, 8, 1'b1);
		i_bp.window(8'h00, 8'h00, 8, 1'b1);
		check(activity_flag, 8'h00);
		// RZ: line b pulses last before energy, so line a means space
		format_sel <= 1'b1;
		cyc(4);
		tx_line_b <= 1'b0;
		cyc(4);
		tx_line_b <= 1'b1;
		cyc(6);
		check(activity_flag, 8'h00);
		rx_energy_n <= 1'b0;
		cyc(6);
		check(activity_flag, 8'h00);
		tx_line_a <= 1'b0;
		cyc(4);
		tx_line_a <= 1'b1;
		cyc(4);
		check(activity_flag, 8'h01);
		end_of_test();
	end
endmodule
`default_nettype wire
